/* logic/gdp_gpio.sv */
// Operation
// - direction bit 0 means input, 1 means output
// - direction bit n governs pin n+1
// - pull enable 0 leaves no pull device; 1 engages one
// - engaged pull polarity comes from the matching pull select bit
// - pull enable is an eight-bit read/write register at offset 2Ch
// - pull enable bit 7 is pin 8, lower bits lower pins
// - output pins drive data bit; data reads return live level of input pins
// - pull select 0 engages pulldown, 1 engages pullup
`timescale 1ns/1ps
`default_nettype none
module gdp_gpio (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // pins
  input  wire logic [7:0]         pin_in,
  output gdp_pkg::gdp_pad_t       pad
);
  import gdp_pkg::*;

  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] pull_en_q;
  logic [7:0] pull_sel_q;
  logic [31:0] prdata_q;
  logic        slverr_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // upper address bits must be zero; anything else is unmapped
  wire        acc      = psel && penable;
  wire        wr_acc   = acc && pwrite && pstrb[0];
  wire        hi_zero  = (paddr[11:10] == 2'b00);
  wire        hit_data = hi_zero && (paddr[9:0] == GDP_ADDR_DATA);
  wire        hit_dir  = hi_zero && (paddr[9:0] == GDP_ADDR_DIR);
  wire        hit_pen  = hi_zero && (paddr[9:0] == GDP_ADDR_PULL_EN);
  wire        hit_psel = hi_zero && (paddr[9:0] == GDP_ADDR_PULL_SEL);
  wire        mapped   = hit_data | hit_dir | hit_pen | hit_psel;
  // data read mixes written value and live level
  wire [7:0]  data_rd  = (dir_q & data_q) | (~dir_q & pin_in);
  wire [7:0]  rd_byte  = hit_data ? data_rd :
                         hit_dir  ? dir_q :
                         hit_pen  ? pull_en_q :
                         hit_psel ? pull_sel_q : 8'h00;

  // zero wait states: access phase always completes in one cycle
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q     <= GDP_RST_DATA;
      dir_q      <= GDP_RST_DIR;
      pull_en_q  <= GDP_RST_PULL_EN;
      pull_sel_q <= GDP_RST_PULL_SEL;
    end else if (wr_acc) begin
      if (hit_data) data_q <= pwdata[7:0];
      if (hit_dir) dir_q <= pwdata[7:0];
      if (hit_pen) pull_en_q <= pwdata[7:0];
      if (hit_psel) pull_sel_q <= pwdata[7:0];
    end
  end

  // read data registered at the setup cycle so it stands in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      slverr_q <= !mapped;
    end
  end

  // ----------------------------------------------------------------
  // pad control, one slice per pin
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < GDP_NPINS; g++) begin : g_pin
      // direction bit g drives pin g+1
      assign pad.out_en[g]    = dir_q[g];
      assign pad.out_val[g]   = data_q[g];
      assign pad.pull_up[g]   = pull_en_q[g] && pull_sel_q[g];
      assign pad.pull_down[g] = pull_en_q[g] && !pull_sel_q[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_dir_oe: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_dir) |=> (pad.out_en == $past(pwdata[7:0])))
    else $error("pin enable does not follow direction write");
  chk_pin_map: assert property (@(posedge pclk) disable iff (!presetn)
    pad.out_en[2] == dir_q[2] && pad.out_en[0] == dir_q[0])
    else $error("direction bit mapping wrong");
  chk_no_pull: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_pen && pwdata[0] == 1'b0)
      |=> !pad.pull_up[0] && !pad.pull_down[0])
    else $error("pull engaged while disabled");
  chk_pull_sel: assert property (@(posedge pclk) disable iff (!presetn)
    pull_en_q[3] |-> (pad.pull_up[3] != pad.pull_down[3]))
    else $error("no single pull chosen");
  chk_pen_read: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_pen) |=> (prdata[7:0] == $past(pull_en_q)
      && prdata[31:8] == 24'h00_0000))
    else $error("pull enable readback wrong");
  chk_pen_bit7: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_pen) |=> ((pad.pull_up[7] | pad.pull_down[7]) == $past(pwdata[7])))
    else $error("pin 8 pull not from bit 7");
  chk_data_rd: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_data && dir_q == 8'h00)
      |=> prdata[7:0] == $past(pin_in))
    else $error("input pins not read live");
  chk_pull_pol: assert property (@(posedge pclk) disable iff (!presetn)
    (pull_en_q[5] && !pull_sel_q[5]) |-> pad.pull_down[5] && !pad.pull_up[5])
    else $error("pulldown not engaged for select 0");
  chk_pull_up: assert property (@(posedge pclk) disable iff (!presetn)
    (pull_en_q[6] && pull_sel_q[6]) |-> pad.pull_up[6] && !pad.pull_down[6])
    else $error("pullup not engaged for select 1");
  chk_out_val: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && hit_data) |=> (pad.out_val == $past(pwdata[7:0])))
    else $error("pin value does not follow data write");
  chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !mapped) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_strb_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && pwrite && !pstrb[0] && hit_dir) |=> $stable(dir_q))
    else $error("direction changed without byte strobe");
endmodule
`default_nettype wire

/* logic/gdp_pkg.sv */
`default_nettype none
package gdp_pkg;
  // register byte addresses; the printed offsets are not all multiples of four, so
  // each printed offset is an index and the byte address is four times it
  localparam logic [7:0] GDP_IDX_DATA     = 8'h2A;
  localparam logic [7:0] GDP_IDX_DIR      = 8'h2B;
  localparam logic [7:0] GDP_IDX_PULL_EN  = 8'h2C;
  localparam logic [7:0] GDP_IDX_PULL_SEL = 8'h2D;
  localparam logic [9:0] GDP_ADDR_DATA     = {GDP_IDX_DATA, 2'b00};
  localparam logic [9:0] GDP_ADDR_DIR      = {GDP_IDX_DIR, 2'b00};
  localparam logic [9:0] GDP_ADDR_PULL_EN  = {GDP_IDX_PULL_EN, 2'b00};
  localparam logic [9:0] GDP_ADDR_PULL_SEL = {GDP_IDX_PULL_SEL, 2'b00};
  localparam int         GDP_NPINS         = 8;
  // reset values
  localparam logic [7:0] GDP_RST_DATA      = 8'h00;
  localparam logic [7:0] GDP_RST_DIR       = 8'h00;
  localparam logic [7:0] GDP_RST_PULL_EN   = 8'hFF;
  localparam logic [7:0] GDP_RST_PULL_SEL  = 8'hFF;
  // per-pin pad controls travel together
  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] out_en;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } gdp_pad_t;
endpackage
`default_nettype wire

/* tb/gdp_board.sv */
`timescale 1ns/1ps
`default_nettype none
module gdp_board (
  // pad controls from the device
  input  wire gdp_pkg::gdp_pad_t pad,
  // board drive: value and per-pin drive enable
  input  wire logic [7:0]        ext_val,
  input  wire logic [7:0]        ext_drv,
  // level seen back by the device
  output logic      [7:0]        pin_lvl
);
  import gdp_pkg::*;
  // pin level from drivers and pulls
  // an undriven, unpulled pin shows the inverse of the board's ext_val bit
  assign pin_lvl = (pad.out_en & pad.out_val) | (~pad.out_en & ((ext_drv & ext_val)
    | (~ext_drv & pad.pull_up) | (~ext_drv & ~pad.pull_up & ~pad.pull_down & ~ext_val)));
endmodule
`default_nettype wire

/* tb/test_gdp_gpio.sv */
`timescale 1ns/1ps
`default_nettype none
module test_gdp_gpio;
  import gdp_pkg::*;
  localparam logic [11:0] A_DT = {2'b00, GDP_ADDR_DATA};
  localparam logic [11:0] A_DR = {2'b00, GDP_ADDR_DIR};
  localparam logic [11:0] A_PE = {2'b00, GDP_ADDR_PULL_EN};
  localparam logic [11:0] A_PS = {2'b00, GDP_ADDR_PULL_SEL};
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [7:0]  pin_in, ev = 0, ed = 0, dt, dr, pe, ps;
  gdp_pad_t    pad;
  int          err_count = 0, total_checks = 0, seed = 32'h6ed5;
  initial forever #50 pclk = ~pclk;
  gdp_gpio dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pad(pad));
  gdp_board brd (.pad(pad), .ext_val(ev), .ext_drv(ed), .pin_lvl(pin_in));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 0; penable <= 0;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // expected live level of input pins; output pins echo the data bit
  function logic [7:0] lvl();
    return (dr & dt) | (~dr & ((ed & ev) | (~ed & pe & ps) | (~ed & ~pe & ~ev)));
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #500000; err_count++; close_out;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    acc(0, A_DR, 0); chk(rd, {24'h0, GDP_RST_DIR});
    acc(0, A_PE, 0); chk(rd, {24'h0, GDP_RST_PULL_EN});
    chk(pad, {16'h0000, GDP_RST_PULL_EN & GDP_RST_PULL_SEL, 8'h00});
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      dt = $random(seed); dr = (i == 0) ? 8'h04 : $random(seed); pe = (i == 1) ? 8'h80 : $random(seed);
      ps = $random(seed); ev = $random(seed); ed = $random(seed);
      acc(1, A_DT, dt); acc(1, A_DR, dr); acc(1, A_PE, pe); acc(1, A_PS, ps);
      // pad follows the registers only after the write edge has settled
      @(negedge pclk);
      chk(pad, {dt, dr, pe & ps, pe & ~ps});
      acc(0, A_DT, 0); chk(rd, {24'h0, lvl()});
      acc(0, A_PE, 0); chk(rd, {24'h0, pe});
    end
    $display("random test done");
    pstrb <= 4'h0; acc(1, A_DR, ~dr); pstrb <= 4'hf;
    acc(0, A_DR, 0); chk(rd, {24'h0, dr});
    acc(0, 12'h0b8, 0); chk(rd, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    $display("refusal test done");
    close_out;
  end
endmodule
`default_nettype wire
